// ---- src/led_string_driver.sv ----
/*
 addressable rgb led string driver with axi4-lite registers and user ram.
 assumes dma_busy, shifter_busy and bar_value come from same-clock logic.
*/
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
// Notes on behaviour
// - test mode lights one led at a time, stepping each refresh
// - direct mode sends each led its last host-written colour
// - animation mode rotates stored frames at configured rate
// - bar mode: two-colour bar, length from 16-bit source value
// - buffer fetch plus shifter clock bits out without processor help
// - output buffer sized about fifty bytes per led
// - buffer lives in 8k user ram at host-chosen index
// - animation frames form a separate ram region, each with delay
// - each frame is two delay bytes plus three bytes per led
// - encoding spread over many 1 ms frames, one led each
// - refresh about every N plus 20 ms
// - busy dma or shifter postpones sending, never drops it
// - animation keeps running without host traffic
`timescale 1ns/1ps
`include "led_string_defines.svh"
module led_string_driver #(
    parameter int MAX_LEDS = `LS_MAX_LEDS,
    parameter int RAM_BYTES = `LS_RAM_BYTES,
    parameter int MS_CYCLES = `LS_MS_CYC,
    parameter int LATCH_CYCLES = `LS_LATCH_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] bar_value,
    input wire logic dma_busy,
    input wire logic shifter_busy,
    output logic res_claim,
    output logic led_dout
);
localparam int AW = $clog2(RAM_BYTES);
localparam int MW = $clog2(MS_CYCLES);
localparam int TW = $clog2(LATCH_CYCLES + `LS_BIT_CYC + 1);
localparam logic [TW-1:0] T0H = TW'(`LS_T0H_CYC);
localparam logic [TW-1:0] T1H = TW'(`LS_T1H_CYC);
localparam logic [TW-1:0] TBIT = TW'(`LS_BIT_CYC);
localparam logic [TW-1:0] TLATCH = TW'(LATCH_CYCLES);
logic rst_meta_reg, rst_n_sync_reg;
always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        rst_meta_reg <= 1'b0;
        rst_n_sync_reg <= 1'b0;
    end else begin
        rst_meta_reg <= 1'b1;
        rst_n_sync_reg <= rst_meta_reg;
    end
end
default clocking dc @(posedge core_clk); endclocking
default disable iff (!rst_n_sync_reg);
logic [MW-1:0] ms_reg, ms_next;
logic tick;
always_comb begin
    tick = (ms_reg == MW'(MS_CYCLES - 1));
    ms_next = tick ? '0 : ms_reg + 1'b1;
end
always_ff @(posedge core_clk or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) ms_reg <= '0;
    else ms_reg <= ms_next;
end
logic [7:0] user_ram [RAM_BYTES];
logic [23:0] led_color [MAX_LEDS];
logic ram_we, color_we, fsm_we, host_we;
logic [AW-1:0] ram_waddr, fsm_waddr, fsm_raddr;
logic [7:0] ram_wdata, fsm_wdata, ram_rdata;
logic [31:0] wv;
ls_pkg::seq_state_t st_reg, st_next;
ls_pkg::disp_mode_t mode_reg, mode_next;
logic [3:0] step_reg, step_next;
logic [7:0] led_reg, led_next, test_reg, test_next, frame_reg, frame_next;
logic [9:0] byte_reg, byte_next;
logic [2:0] bit_reg, bit_next;
logic [7:0] sh_reg, sh_next;
logic [TW-1:0] t_reg, t_next;
logic [15:0] per_reg, per_next, fms_reg, fms_next, fdly_reg, fdly_next;
logic [23:0] rgb_reg, rgb_next, color, fsz, fbase, lo;
logic [23:0] prod;
logic dout_reg, dout_next;
logic have_aw_reg, have_aw_next, have_w_reg, have_w_next;
logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
logic [7:0] waddr_reg, waddr_next;
logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
logic [3:0] wstrb_reg, wstrb_next;
logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
logic en_reg, en_next;
logic [7:0] num_reg, num_next, frames_reg, frames_next, sel_reg, sel_next;
logic [AW-1:0] buf_reg, buf_next, anim_reg, anim_next, ptr_reg, ptr_next;
logic [23:0] fg_reg, fg_next, bg_reg, bg_next;
function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
        if (be[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
endfunction
function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `LS_OFS_BUFSZ);
endfunction
function automatic logic [31:0] rd_val(input logic [7:0] a);
    case (a)
        `LS_OFS_CTRL: return {29'h0, mode_reg, en_reg};
        `LS_OFS_NUM: return {24'h0, num_reg};
        `LS_OFS_BUF: return 32'(buf_reg);
        `LS_OFS_ANIM: return 32'(anim_reg);
        `LS_OFS_FRAMES: return {24'h0, frames_reg};
        `LS_OFS_SEL: return {24'h0, sel_reg};
        `LS_OFS_COLOR: return (sel_reg < MAX_LEDS) ? {8'h0, led_color[sel_reg]} : 32'h0;
        `LS_OFS_FG: return {8'h0, fg_reg};
        `LS_OFS_BG: return {8'h0, bg_reg};
        `LS_OFS_PTR: return 32'(ptr_reg);
        `LS_OFS_DATA: return {24'h0, user_ram[ptr_reg]};
        `LS_OFS_STATUS: return {16'h0, frame_reg, 3'h0, st_reg};
        // buffer size, fifty bytes per led
        `LS_OFS_BUFSZ: return 32'(num_reg) * 32'(`LS_ENC_BYTES);
        default: return 32'h0;
    endcase
endfunction
assign s_axi_awready = !have_aw_reg && !bvalid_reg;
assign s_axi_wready = !have_w_reg && !bvalid_reg;
assign s_axi_bvalid = bvalid_reg;
assign s_axi_bresp = bresp_reg;
assign s_axi_arready = !rvalid_reg;
assign s_axi_rvalid = rvalid_reg;
assign s_axi_rdata = rdata_reg;
assign s_axi_rresp = rresp_reg;
always_comb begin
    {have_aw_next, have_w_next, bvalid_next, rvalid_next} =
        {have_aw_reg, have_w_reg, bvalid_reg, rvalid_reg};
    {waddr_next, wdata_next, wstrb_next, bresp_next} =
        {waddr_reg, wdata_reg, wstrb_reg, bresp_reg};
    {rdata_next, rresp_next, en_next, mode_next} = {rdata_reg, rresp_reg, en_reg, mode_reg};
    {num_next, frames_next, sel_next, fg_next, bg_next} =
        {num_reg, frames_reg, sel_reg, fg_reg, bg_reg};
    {buf_next, anim_next, ptr_next} = {buf_reg, anim_reg, ptr_reg};
    host_we = 1'b0;
    color_we = 1'b0;
    wv = merge(rd_val(waddr_reg), wdata_reg, wstrb_reg);
    if (s_axi_awvalid && s_axi_awready) begin
        have_aw_next = 1'b1;
        waddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
        have_w_next = 1'b1;
        wdata_next = s_axi_wdata;
        wstrb_next = s_axi_wstrb;
    end
    // ram writes wait while the renderer owns the port
    if (have_aw_reg && have_w_reg && !(waddr_reg == `LS_OFS_DATA && fsm_we)) begin
        {have_aw_next, have_w_next, bvalid_next} = 3'h1;
        bresp_next = mapped(waddr_reg) ? `LS_RESP_OKAY : `LS_RESP_SLVERR;
        case (waddr_reg)
            `LS_OFS_CTRL: begin
                en_next = wv[`LS_CTRL_EN_BIT];
                mode_next = ls_pkg::disp_mode_t'(wv[`LS_CTRL_MODE_LSB +: 2]);
            end
            `LS_OFS_NUM: num_next = (wv[7:0] > MAX_LEDS) ? 8'(MAX_LEDS) : wv[7:0];
            `LS_OFS_BUF: buf_next = wv[AW-1:0];
            `LS_OFS_ANIM: anim_next = wv[AW-1:0];
            `LS_OFS_FRAMES: frames_next = wv[7:0];
            `LS_OFS_SEL: sel_next = wv[7:0];
            `LS_OFS_COLOR: color_we = (sel_reg < MAX_LEDS);
            `LS_OFS_FG: fg_next = wv[23:0];
            `LS_OFS_BG: bg_next = wv[23:0];
            `LS_OFS_PTR: ptr_next = wv[AW-1:0];
            `LS_OFS_DATA: begin
                host_we = 1'b1;
                ptr_next = ptr_reg + 1'b1;
            end
            default: host_we = 1'b0;
        endcase
    end
    if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
    if (rvalid_reg && s_axi_rready) rvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
        rvalid_next = 1'b1;
        rdata_next = rd_val(s_axi_araddr);
        rresp_next = mapped(s_axi_araddr) ? `LS_RESP_OKAY : `LS_RESP_SLVERR;
    end
end
always_ff @(posedge core_clk or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
        {have_aw_reg, have_w_reg, bvalid_reg, rvalid_reg, en_reg} <= 5'h0;
        {waddr_reg, wdata_reg, wstrb_reg, bresp_reg} <= '0;
        {rdata_reg, rresp_reg, num_reg, frames_reg, sel_reg} <= '0;
        {fg_reg, bg_reg, buf_reg, anim_reg, ptr_reg} <= '0;
        mode_reg <= ls_pkg::MODE_TEST;
    end else begin
        {have_aw_reg, have_w_reg, bvalid_reg, rvalid_reg, en_reg} <=
            {have_aw_next, have_w_next, bvalid_next, rvalid_next, en_next};
        {waddr_reg, wdata_reg, wstrb_reg, bresp_reg} <=
            {waddr_next, wdata_next, wstrb_next, bresp_next};
        {rdata_reg, rresp_reg, num_reg, frames_reg, sel_reg} <=
            {rdata_next, rresp_next, num_next, frames_next, sel_next};
        {fg_reg, bg_reg, buf_reg, anim_reg, ptr_reg} <=
            {fg_next, bg_next, buf_next, anim_next, ptr_next};
        mode_reg <= mode_next;
    end
end
always_comb begin
    fsm_we = (st_reg == ls_pkg::ST_RENDER) && (step_reg >= 4'h6);
    ram_we = fsm_we || host_we;
    ram_waddr = fsm_we ? fsm_waddr : ptr_reg;
    ram_wdata = fsm_we ? fsm_wdata : wv[7:0];
    ram_rdata = user_ram[fsm_raddr];
end
always_ff @(posedge core_clk) begin
    if (ram_we) user_ram[ram_waddr] <= ram_wdata;
    if (color_we) led_color[sel_reg] <= wv[23:0];
end
always_comb begin
    // frame is delay word plus rgb per led
    fsz = 24'(num_reg) * 24'(`LS_RGB_BYTES) + 24'(`LS_FRAME_HDR);
    // frames sit in their own region
    fbase = 24'(anim_reg) + 24'(frame_reg) * fsz;
    lo = 24'(led_reg) * 24'(`LS_RGB_BYTES);
    prod = 24'(bar_value) * 24'(num_reg);
    case (mode_reg)
        // only the current test position lit
        ls_pkg::MODE_TEST: color = (led_reg == test_reg) ? `LS_TEST_COLOR : 24'h0;
        // last host colour for this led
        ls_pkg::MODE_DIRECT: color = (led_reg < MAX_LEDS) ? led_color[led_reg] : 24'h0;
        ls_pkg::MODE_ANIM: color = rgb_reg;
        // lit length scales with the source value
        ls_pkg::MODE_BAR: color = (led_reg < prod[23:16]) ? fg_reg : bg_reg;
        default: color = 24'h0;
    endcase
    case (step_reg)
        4'h6: fsm_wdata = color[15:8];
        4'h7: fsm_wdata = color[23:16];
        default: fsm_wdata = color[7:0];
    endcase
    fsm_waddr = AW'(24'(buf_reg) + lo + 24'(step_reg) - 24'h6);
    case (st_reg)
        ls_pkg::ST_CLAIM: fsm_raddr = buf_reg + AW'(byte_reg);
        ls_pkg::ST_SEND: fsm_raddr = buf_reg + AW'(byte_reg) + 1'b1;
        default: fsm_raddr = (step_reg < 4'h3) ? AW'(fbase + 24'(step_reg) - 24'h1) :
                             AW'(fbase + lo + 24'(step_reg) - 24'h1);
    endcase
end
always_comb begin
    {st_next, step_next, led_next, test_next, frame_next} =
        {st_reg, step_reg, led_reg, test_reg, frame_reg};
    {byte_next, bit_next, sh_next, t_next} = {byte_reg, bit_reg, sh_reg, t_reg};
    {per_next, fms_next, fdly_next, rgb_next} = {per_reg, fms_reg, fdly_reg, rgb_reg};
    if (tick && per_reg != 16'hffff) per_next = per_reg + 16'h1;
    // frame rotation runs on its own
    if (tick && en_reg && mode_reg == ls_pkg::MODE_ANIM) begin
        if (fms_reg + 16'h1 >= fdly_reg) begin
            fms_next = 16'h0;
            frame_next = (frame_reg + 8'h1 >= frames_reg) ? 8'h0 : frame_reg + 8'h1;
        end else begin
            fms_next = fms_reg + 16'h1;
        end
    end
    case (st_reg)
        ls_pkg::ST_IDLE: begin
            if (en_reg && num_reg != 8'h0) begin
                {st_next, led_next, step_next, per_next} = {ls_pkg::ST_RENDER, 28'h0};
            end
        end
        ls_pkg::ST_RENDER: begin
            if (step_reg == 4'h1 && led_reg == 8'h0) fdly_next[7:0] = ram_rdata;
            if (step_reg == 4'h2 && led_reg == 8'h0) fdly_next[15:8] = ram_rdata;
            if (step_reg == 4'h3) rgb_next[23:16] = ram_rdata;
            if (step_reg == 4'h4) rgb_next[15:8] = ram_rdata;
            if (step_reg == 4'h5) rgb_next[7:0] = ram_rdata;
            // one led encoded per 1 ms tick
            if (step_reg == 4'h0) begin
                if (tick) step_next = 4'h1;
            end else if (step_reg == 4'h8) begin
                step_next = 4'h0;
                if (led_reg + 8'h1 == num_reg) begin
                    st_next = ls_pkg::ST_CLAIM;
                    byte_next = 10'h0;
                end else begin
                    led_next = led_reg + 8'h1;
                end
            end else begin
                step_next = step_reg + 4'h1;
            end
        end
        ls_pkg::ST_CLAIM: begin
            // wait for both resources, keep frame
            if (!dma_busy && !shifter_busy) begin
                st_next = ls_pkg::ST_SEND;
                {sh_next, bit_next, t_next} = {ram_rdata, 3'h7, TW'(0)};
            end
        end
        ls_pkg::ST_SEND: begin
            // buffer fetch feeds the bit shifter
            if (t_reg == TBIT - 1'b1) begin
                t_next = '0;
                sh_next = {sh_reg[6:0], 1'b0};
                bit_next = bit_reg - 3'h1;
                if (bit_reg == 3'h0) begin
                    byte_next = byte_reg + 10'h1;
                    sh_next = ram_rdata;
                    if (byte_reg + 10'h1 == 10'(num_reg) * 10'(`LS_RGB_BYTES)) begin
                        st_next = ls_pkg::ST_HOLD;
                    end
                end
            end else begin
                t_next = t_reg + 1'b1;
            end
        end
        ls_pkg::ST_HOLD: begin
            // line low through the latch time
            if (t_reg < TLATCH) t_next = t_reg + 1'b1;
            // restart at N plus 20 ms
            if (t_reg >= TLATCH && per_reg >= 16'(num_reg) + 16'(`LS_EXTRA_MS)) begin
                test_next = (test_reg + 8'h1 >= num_reg) ? 8'h0 : test_reg + 8'h1;
                st_next = ls_pkg::ST_IDLE;
                if (en_reg && num_reg != 8'h0) begin
                    {st_next, led_next, step_next, per_next} = {ls_pkg::ST_RENDER, 28'h0};
                end
            end
        end
        default: st_next = ls_pkg::ST_IDLE;
    endcase
    // high time picks the bit value
    dout_next = (st_next == ls_pkg::ST_SEND) && (t_next < (sh_next[7] ? T1H : T0H));
end
always_ff @(posedge core_clk or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
        st_reg <= ls_pkg::ST_IDLE;
        {step_reg, led_reg, test_reg, frame_reg, byte_reg, bit_reg, sh_reg} <= '0;
        {t_reg, per_reg, fms_reg, fdly_reg, rgb_reg, dout_reg} <= '0;
    end else begin
        st_reg <= st_next;
        {step_reg, led_reg, test_reg, frame_reg, byte_reg, bit_reg, sh_reg} <=
            {step_next, led_next, test_next, frame_next, byte_next, bit_next, sh_next};
        {t_reg, per_reg, fms_reg, fdly_reg, rgb_reg, dout_reg} <=
            {t_next, per_next, fms_next, fdly_next, rgb_next, dout_next};
    end
end
assign led_dout = dout_reg;
assign res_claim = (st_reg == ls_pkg::ST_SEND);
property p_test_dark;
    fsm_we && mode_reg == ls_pkg::MODE_TEST && led_reg != test_reg |-> ram_wdata == 8'h0;
endproperty
a_test_dark: assert property (p_test_dark) else $error("test mode lit wrong led");
property p_direct;
    fsm_we && step_reg == 4'h6 && mode_reg == ls_pkg::MODE_DIRECT
        |-> ram_wdata == led_color[led_reg][15:8];
endproperty
a_direct: assert property (p_direct) else $error("direct colour mismatch");
property p_frame_step;
    tick && en_reg && mode_reg == ls_pkg::MODE_ANIM && frames_reg > 8'h1
        && fms_reg + 16'h1 >= fdly_reg |=> frame_reg != $past(frame_reg);
endproperty
a_frame_step: assert property (p_frame_step) else $error("frame did not advance");
property p_bar;
    fsm_we && step_reg == 4'h7 && mode_reg == ls_pkg::MODE_BAR
        |-> ram_wdata == ((led_reg < prod[23:16]) ? fg_reg[23:16] : bg_reg[23:16]);
endproperty
a_bar: assert property (p_bar) else $error("bar colour wrong");
sequence s_led_done;
    st_reg == ls_pkg::ST_RENDER && step_reg == 4'h8 && led_reg + 8'h1 != num_reg;
endsequence
property p_one_led_per_tick;
    s_led_done |=> step_reg == 4'h0 && led_reg == $past(led_reg) + 8'h1;
endproperty
a_one_led_per_tick: assert property (p_one_led_per_tick) else $error("render not paced");
property p_postpone;
    st_reg == ls_pkg::ST_CLAIM && (dma_busy || shifter_busy) |=> st_reg == ls_pkg::ST_CLAIM;
endproperty
a_postpone: assert property (p_postpone) else $error("sent while busy");
property p_one_bit;
    st_reg == ls_pkg::ST_SEND && sh_reg[7] && t_reg < T1H |-> dout_reg;
endproperty
a_one_bit: assert property (p_one_bit) else $error("one bit high too short");
property p_zero_bit;
    st_reg == ls_pkg::ST_SEND && !sh_reg[7] && t_reg >= T0H |-> !dout_reg;
endproperty
a_zero_bit: assert property (p_zero_bit) else $error("zero bit high too long");
property p_latch_low;
    st_reg == ls_pkg::ST_HOLD |-> !dout_reg && !res_claim;
endproperty
a_latch_low: assert property (p_latch_low) else $error("line not low in latch");
property p_refresh;
    st_reg == ls_pkg::ST_HOLD && per_reg < 16'(num_reg) + 16'(`LS_EXTRA_MS)
        |=> st_reg == ls_pkg::ST_HOLD;
endproperty
a_refresh: assert property (p_refresh) else $error("refresh too early");
endmodule // led_string_driver

// ---- src/led_string_defines.svh ----
/*
 constants for the addressable rgb led string driver.
 assumes a 100 MHz core clock and a byte-wide shared user ram.
*/
`ifndef LED_STRING_DEFINES_SVH
`define LED_STRING_DEFINES_SVH
`define LS_CLK_MHZ 100
`define LS_T0H_NS 400
`define LS_T1H_NS 800
`define LS_BIT_NS 1250
`define LS_LATCH_US 80
`define LS_FRAME_MS 1
`define LS_T0H_CYC ((`LS_T0H_NS * `LS_CLK_MHZ) / 1000)
`define LS_T1H_CYC ((`LS_T1H_NS * `LS_CLK_MHZ) / 1000)
`define LS_BIT_CYC ((`LS_BIT_NS * `LS_CLK_MHZ) / 1000)
`define LS_LATCH_CYC (`LS_LATCH_US * `LS_CLK_MHZ)
`define LS_MS_CYC (`LS_FRAME_MS * 1000 * `LS_CLK_MHZ)
`define LS_EXTRA_MS 20
`define LS_ENC_BYTES 50
`define LS_FRAME_HDR 2
`define LS_RGB_BYTES 3
`define LS_RAM_BYTES 8192
`define LS_MAX_LEDS 160
`define LS_TEST_COLOR 24'h0f0f0f
`define LS_CTRL_EN_BIT 0
`define LS_CTRL_MODE_LSB 1
`define LS_OFS_CTRL 8'h00
`define LS_OFS_NUM 8'h04
`define LS_OFS_BUF 8'h08
`define LS_OFS_ANIM 8'h0c
`define LS_OFS_FRAMES 8'h10
`define LS_OFS_SEL 8'h14
`define LS_OFS_COLOR 8'h18
`define LS_OFS_FG 8'h1c
`define LS_OFS_BG 8'h20
`define LS_OFS_PTR 8'h24
`define LS_OFS_DATA 8'h28
`define LS_OFS_STATUS 8'h2c
`define LS_OFS_BUFSZ 8'h30
`define LS_RESP_OKAY 2'h0
`define LS_RESP_SLVERR 2'h2
`endif

// ---- src/ls_pkg.sv ----
/*
 types for the led string driver.
 assumes nothing beyond the defines header.
*/
package ls_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RENDER = 5'h02,
        ST_CLAIM = 5'h04,
        ST_SEND = 5'h08,
        ST_HOLD = 5'h10
    } seq_state_t;
    typedef enum logic [1:0] {
        MODE_TEST = 2'h0,
        MODE_DIRECT = 2'h1,
        MODE_ANIM = 2'h2,
        MODE_BAR = 2'h3
    } disp_mode_t;
endpackage

// ---- verification/led_string_rx.sv ----
/*
 decoding model of the led string on the data line.
 assumes the 100 MHz core clock and a push-pull line.
*/
`timescale 1ns/1ps
module led_string_rx (
    input wire logic core_clk,
    input wire logic led_dout,
    output logic [23:0] word0,
    output logic [23:0] word1,
    output int frames
);
    int hi_cnt = 0;
    int lo_cnt = 0;
    int nbits = 0;
    logic [47:0] shreg = '0;
    initial word0 = '0;
    initial word1 = '0;
    initial frames = 0;
    always @(posedge core_clk) begin
        if (led_dout) begin
            hi_cnt <= hi_cnt + 1;
            lo_cnt <= 0;
        end else begin
            if (hi_cnt != 0) begin
                shreg <= {shreg[46:0], hi_cnt > 60};
                nbits <= nbits + 1;
            end
            hi_cnt <= 0;
            lo_cnt <= lo_cnt + 1;
            if (lo_cnt == 150 && nbits == 48) begin
                word0 <= shreg[47:24];
                word1 <= shreg[23:0];
                frames <= frames + 1;
            end
            if (lo_cnt == 150) begin
                nbits <= 0;
            end
        end
    end
endmodule // led_string_rx

// ---- verification/tb_addressable_rgb_led_string_driver.sv ----
/*
 self-checking bench for the led string driver, two leds.
 assumes short ms and latch parameters to keep the run brief.
*/
`timescale 1ns/1ps
module tb_addressable_rgb_led_string_driver;
    logic core_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd_d;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, res_claim, led_dout;
    logic [1:0] bresp, rresp, rd_r, wr_r;
    logic [15:0] bar_value = '0;
    logic dma_busy = 0, shifter_busy = 0;
    logic [23:0] word0, word1;
    int frames, bad_count = 0, total_checks = 0;
    led_string_driver #(.MS_CYCLES(40), .LATCH_CYCLES(200)) u_dut (.core_clk(core_clk),
        .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bar_value(bar_value), .dma_busy(dma_busy),
        .shifter_busy(shifter_busy), .res_claim(res_claim), .led_dout(led_dout));
    led_string_rx u_rx (.core_clk(core_clk), .led_dout(led_dout), .word0(word0),
        .word1(word1), .frames(frames));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ap, wp, ao, wo;
        @(posedge core_clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        ap = 1; wp = 1;
        while (ap || wp) begin
            @(negedge core_clk); ao = awready; wo = wready;
            @(posedge core_clk);
            if (ap && ao) begin awvalid <= 0; ap = 0; end
            if (wp && wo) begin wvalid <= 0; wp = 0; end
        end
        do @(negedge core_clk); while (!bvalid);
        wr_r = bresp;
        @(posedge core_clk);
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(negedge core_clk); while (!arready);
        @(posedge core_clk);
        arvalid <= 0;
        do @(negedge core_clk); while (!rvalid);
        rd_d = rdata; rd_r = rresp;
        @(posedge core_clk);
        rready <= 0;
    endtask
    task automatic wait_frames(input int k);
        int f0 = frames;
        int n = 0;
        while (frames < f0 + k && n < 20000) begin @(negedge core_clk); n++; end
        chk("frame seen", 1, n < 20000);
    endtask
    task automatic t_regs;
        wr(8'h04, 32'h2);
        chk("write resp", 2'h0, wr_r);
        wr(8'h34, 32'h1);
        chk("unmapped write resp", 2'h2, wr_r);
        rd(8'h30); chk("bufsz", 32'd100, rd_d);
        rd(8'h34); chk("unmapped resp", 2'h2, rd_r);
        chk("unmapped data", 0, rd_d);
        $display("test done: regs");
    endtask
    task automatic t_direct_busy;
        wr(8'h14, 0); wr(8'h18, 32'h123456);
        wr(8'h14, 1); wr(8'h18, 32'habcdef);
        @(posedge core_clk) dma_busy <= 1;
        wr(8'h00, 32'h3);
        repeat (1500) @(posedge core_clk);
        rd(8'h2c); chk("claim held", 5'h04, rd_d[4:0]);
        @(negedge core_clk);
        chk("no shift while busy", 0, res_claim);
        @(posedge core_clk) begin dma_busy <= 0; shifter_busy <= 1; end
        repeat (200) @(posedge core_clk);
        chk("no frame while shifter busy", 0, frames);
        @(posedge core_clk) shifter_busy <= 0;
        wait_frames(1);
        chk("led0 grb", 24'h341256, word0);
        chk("led1 grb", 24'hcdabef, word1);
        $display("test done: direct");
    endtask
    task automatic t_bar;
        wr(8'h1c, 32'h010203); wr(8'h20, 32'h0a0b0c);
        @(posedge core_clk) bar_value <= 16'h8000;
        wr(8'h00, 32'h7);
        wait_frames(2);
        chk("bar lit", 24'h020103, word0);
        chk("bar unlit", 24'h0b0a0c, word1);
        $display("test done: bar");
    endtask
    task automatic t_seq;
        logic [47:0] prev;
        wr(8'h00, 32'h1);
        wait_frames(2);
        prev = {word0, word1};
        chk("one lit", 1, prev === {24'h0f0f0f, 24'h0} || prev === {24'h0, 24'h0f0f0f});
        wait_frames(1);
        chk("lit led moved 0", prev[23:0], word0);
        chk("lit led moved 1", prev[47:24], word1);
        $display("test done: sequence");
    endtask
    task automatic t_anim;
        logic [127:0] img = 128'hc800112233000000_c800445566000000;
        logic s0 = 0;
        logic s1 = 0;
        wr(8'h24, 32'd100);
        // two frames of delay word plus rgb per led
        for (int i = 0; i < 16; i++) begin
            wr(8'h28, {24'h0, img[127 - 8 * i -: 8]});
        end
        wr(8'h0c, 32'd100);
        wr(8'h10, 32'h2);
        wr(8'h00, 32'h5);
        // frame in flight may still be test mode
        wait_frames(1);
        // 200 ms delay exceeds one refresh, so three refreshes see a change
        repeat (3) begin
            wait_frames(1);
            if (word0 === 24'h221133) begin
                s0 = 1;
            end else if (word0 === 24'h554466) begin
                s1 = 1;
            end else begin
                chk("anim led0", 24'h221133, word0);
            end
        end
        chk("first frame shown", 1, s0);
        chk("second frame shown", 1, s1);
        $display("test done: animation");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #900000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_direct_busy();
        t_bar();
        t_seq();
        t_anim();
        stop_test();
    end
endmodule // tb_addressable_rgb_led_string_driver
